// file: core/switch_map.vh
// register map, field positions and timing constants of the switch core
`ifndef SWITCH_MAP_VH
`define SWITCH_MAP_VH

// register word indices on the plain register port
`define REG_CFG_BASE   8'h00
`define REG_STS_BASE   8'h10
`define REG_DROPS      8'h20
`define REG_PDV        8'h21

// per-port link configuration fields
`define CFG_AN         0
`define CFG_SPD        1
`define CFG_FDX        2
`define CFG_W          3
`define CFG_RESET      3'h1

// per-port status fields
`define STS_LINK       0
`define STS_SPD        1
`define STS_FDX        2
`define STS_MDIX       3
`define STS_CONG       4
`define STS_W          5

// partner ability bits
`define ABIL_100F      3
`define ABIL_100H      2
`define ABIL_10F       1
`define ABIL_10H       0
`define ABIL_W         4

// frame header layout (byte counts) and group bit of an address
`define HDR_DST_END    6
`define HDR_SRC_END    12
`define MIN_FRAME      12
`define GROUP_BIT      40
`define MAC_W          48

// half duplex contribution to path delay, in bit times
`define PATH_DELAY_BT  8'h32

// crossover hunt dwell
`define CLK_PERIOD_NS  25
`define MDIX_TIME_NS   20000
`define MDIX_CYC       (`MDIX_TIME_NS / `CLK_PERIOD_NS)

// aging period default in cycles (10 s at 40 MHz)
`define AGE_CYC_DEF    32'h17D7_8400

// central scheduler states
`define ST_IDLE        2'h0
`define ST_LOOK        2'h1
`define ST_SEND        2'h2

`endif

// file: core/learning_switch_core.v
// store-and-forward learning switch core with per-port link resolution and flow control
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "switch_map.vh"

// Operation
// - same-port destination frames are discarded
// - known destination goes only to its port
// - multicast frames replicated to every port but the source
// - whole frame stored first; bad frames dropped
// - local traffic never reaches other ports
// - address table holds 8K entries
// - source addresses learned, moved nodes updated
// - aging evicts entries not refreshed since the last sweep
// - table cleared only at power-up reset
// - automatic crossover while auto-negotiating
// - per-port auto-negotiation or fixed speed/duplex
// - auto-negotiation enabled out of reset
// - highest common mode: 100F,100H,10F,10H
// - non-negotiating partner: idle speed, half duplex
// - renegotiate on link up or re-establish
// - half duplex path delay 50 bit times
// - full duplex congestion sends pause frame
// - resume frame once buffer frees
// - half duplex congestion forces collision
module learning_switch_core #(
	parameter        NP         = 4,
	parameter        PW         = 2,
	parameter        FB_AW      = 11,
	parameter        TD_AW      = 13,
	parameter [31:0] AGE_CYCLES = `AGE_CYC_DEF
) (
	input  wire              sys_clk,
	input  wire              rst_n,
	input  wire [7:0]        reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [31:0]       reg_rdata,
	input  wire [NP-1:0]     rx_valid,
	input  wire [NP*8-1:0]   rx_data,
	input  wire [NP-1:0]     rx_last,
	input  wire [NP-1:0]     rx_bad,
	output reg  [NP-1:0]     tx_valid,
	output reg  [7:0]        tx_data,
	output reg               tx_last,
	input  wire [NP-1:0]     tx_ready,
	input  wire [NP-1:0]     link_up,
	input  wire [NP-1:0]     partner_an,
	input  wire [NP*4-1:0]   partner_abil,
	input  wire [NP-1:0]     partner_idle100,
	output reg  [NP-1:0]     mdix_sel,
	output reg  [NP-1:0]     port_100,
	output reg  [NP-1:0]     port_full,
	output reg  [NP-1:0]     force_col,
	output reg  [NP-1:0]     pause_xoff,
	output reg  [NP-1:0]     pause_xon
);
	localparam TD = 1 << TD_AW;
	localparam FB = 1 << FB_AW;
	localparam [15:0] MDIX_LAST = `MDIX_CYC - 1;
	// per-port ingress results, flattened
	wire [NP-1:0]             pend;
	wire [NP-1:0]             bad_p;
	wire [NP*`MAC_W-1:0]      dst_v;
	wire [NP*`MAC_W-1:0]      src_v;
	wire [NP*(FB_AW+1)-1:0]   len_v;
	wire [NP*8-1:0]           rd_bytes;
	wire [NP*`CFG_W-1:0]      cfg_v;
	reg  [NP-1:0]             rel_q;
	reg  [FB_AW:0]            rd_ptr_q;
	// address table: mac/port arrays plus resettable valid and age vectors
	reg  [`MAC_W-1:0]         tbl_mac [0:TD-1];
	reg  [PW-1:0]             tbl_port [0:TD-1];
	reg  [TD-1:0]             tbl_vld_q;
	reg  [TD-1:0]             tbl_age_q;
	function [TD_AW-1:0] hash_idx;
		input [`MAC_W-1:0] m;
		hash_idx = m[TD_AW-1:0] ^ m[2*TD_AW-1:TD_AW] ^ m[`MAC_W-1:`MAC_W-TD_AW];
	endfunction
	genvar p;
	generate
		for (p = 0; p < NP; p = p + 1) begin : g_port
			localparam [7:0] CFG_A = `REG_CFG_BASE + p;
			reg  [7:0]        fbuf [0:FB-1];
			reg  [FB_AW:0]    wp_q;
			reg  [FB_AW:0]    len_q;
			reg               pend_q;
			reg               drop_q;
			reg               bad_q;
			reg  [`MAC_W-1:0] dst_q;
			reg  [`MAC_W-1:0] src_q;
			reg  [`CFG_W-1:0] cfg_q;
			reg               link_prev_q;
			reg  [3:0]        abil_prev_q;
			reg               cong_prev_q;
			reg  [15:0]       mdix_cnt_q;
			wire [7:0]        rb = rx_data[p*8 +: 8];
			wire [3:0]        ab = partner_abil[p*4 +: 4];
			wire              ok = !drop_q && !pend_q && !rx_bad[p] && !wp_q[FB_AW]
			                       && (wp_q >= `MIN_FRAME - 1);
			assign pend[p]                          = pend_q;
			assign bad_p[p]                         = bad_q;
			assign dst_v[p*`MAC_W +: `MAC_W]        = dst_q;
			assign src_v[p*`MAC_W +: `MAC_W]        = src_q;
			assign len_v[p*(FB_AW+1) +: FB_AW+1]    = len_q;
			assign rd_bytes[p*8 +: 8]               = fbuf[rd_ptr_q[FB_AW-1:0]];
			assign cfg_v[p*`CFG_W +: `CFG_W]        = cfg_q;
			// frame store; nothing is written while a held frame awaits forwarding
			always @(posedge sys_clk) begin
				if (rx_valid[p] && !pend_q && !wp_q[FB_AW])
					fbuf[wp_q[FB_AW-1:0]] <= rb;
			end
			// ingress bookkeeping: capture header, judge frame at its last byte
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					wp_q   <= {(FB_AW+1){1'b0}};
					len_q  <= {(FB_AW+1){1'b0}};
					pend_q <= 1'b0;
					drop_q <= 1'b0;
					bad_q  <= 1'b0;
					dst_q  <= {`MAC_W{1'b0}};
					src_q  <= {`MAC_W{1'b0}};
				end else begin
					bad_q <= 1'b0;
					if (rel_q[p])
						pend_q <= 1'b0;
					if (rx_valid[p]) begin
						if (!pend_q && wp_q < `HDR_DST_END)
							dst_q <= {dst_q[`MAC_W-9:0], rb};
						else if (!pend_q && wp_q < `HDR_SRC_END)
							src_q <= {src_q[`MAC_W-9:0], rb};
						if (rx_last[p]) begin
							if (ok) begin
								pend_q <= 1'b1;
								len_q  <= wp_q + 1'b1;
							end else
								bad_q  <= 1'b1;
							wp_q   <= {(FB_AW+1){1'b0}};
							drop_q <= 1'b0;
						end else begin
							if (!wp_q[FB_AW])
								wp_q <= wp_q + 1'b1; // saturate: oversize frame ends as bad
							if (pend_q)
								drop_q <= 1'b1;
						end
					end
				end
			end
			// link configuration register, auto-negotiation on out of reset
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n)
					cfg_q <= `CFG_RESET;
				else if (reg_wr && reg_addr == CFG_A)
					cfg_q <= reg_wdata[`CFG_W-1:0];
			end
			// mode resolution on each link establishment or partner change
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					link_prev_q  <= 1'b0;
					abil_prev_q  <= 4'h0;
					port_100[p]  <= 1'b0;
					port_full[p] <= 1'b0;
				end else begin
					link_prev_q <= link_up[p];
					abil_prev_q <= ab;
					if (link_up[p] && (!link_prev_q || (cfg_q[`CFG_AN] && partner_an[p] && ab != abil_prev_q))) begin
						if (!cfg_q[`CFG_AN]) begin
							port_100[p]  <= cfg_q[`CFG_SPD];
							port_full[p] <= cfg_q[`CFG_FDX];
						end else if (partner_an[p]) begin
							port_100[p]  <= ab[`ABIL_100F] | ab[`ABIL_100H];
							port_full[p] <= ab[`ABIL_100F] |
							                (!ab[`ABIL_100H] & ab[`ABIL_10F]);
						end else begin
							port_100[p]  <= partner_idle100[p];
							port_full[p] <= 1'b0;
						end
					end
				end
			end
			// crossover hunt: flip pair mapping each dwell until link comes up
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					mdix_cnt_q  <= 16'h0000;
					mdix_sel[p] <= 1'b0;
				end else if (!cfg_q[`CFG_AN]) begin
					mdix_cnt_q  <= 16'h0000;
					mdix_sel[p] <= 1'b0;
				end else if (!link_up[p]) begin
					if (mdix_cnt_q == MDIX_LAST) begin
						mdix_cnt_q  <= 16'h0000;
						mdix_sel[p] <= ~mdix_sel[p];
					end else
						mdix_cnt_q <= mdix_cnt_q + 16'h0001;
				end
			end
			// congestion: held frame blocks the port buffer
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					cong_prev_q   <= 1'b0;
					pause_xoff[p] <= 1'b0;
					pause_xon[p]  <= 1'b0;
					force_col[p]  <= 1'b0;
				end else begin
					cong_prev_q   <= pend_q;
					pause_xoff[p] <= port_full[p] & pend_q & ~cong_prev_q;
					pause_xon[p]  <= port_full[p] & ~pend_q & cong_prev_q;
					force_col[p]  <= ~port_full[p] & pend_q & rx_valid[p];
				end
			end
		end
	endgenerate
	// central scheduler state
	reg  [1:0]         state_q;
	reg  [NP-1:0]      mask_q; // frozen at lookup: a learn or sweep mid-frame must not empty it
	reg  [PW-1:0]      sel_q;
	reg  [PW-1:0]      rr_q;
	reg  [31:0]        drops_q;
	reg  [31:0]        age_cnt_q;
	reg                sweep_q;
	reg  [TD_AW-1:0]   sweep_idx_q;
	// round-robin pick among ports holding a complete frame
	reg  [PW-1:0]      pick;
	reg                pick_v;
	integer            i;
	integer            j;
	always @* begin
		pick   = {PW{1'b0}};
		pick_v = 1'b0;
		j      = 0;
		for (i = NP - 1; i >= 0; i = i - 1) begin
			j = (rr_q + 1 + i) % NP;
			if (pend[j]) begin
				pick   = j[PW-1:0];
				pick_v = 1'b1;
			end
		end
	end
	// lookup of the selected frame
	wire [`MAC_W-1:0]  cur_dst = dst_v[sel_q*`MAC_W +: `MAC_W];
	wire [`MAC_W-1:0]  cur_src = src_v[sel_q*`MAC_W +: `MAC_W];
	wire [FB_AW:0]     cur_len = len_v[sel_q*(FB_AW+1) +: FB_AW+1];
	wire [TD_AW-1:0]   si      = hash_idx(cur_src);
	wire [TD_AW-1:0]   di      = hash_idx(cur_dst);
	wire               hit     = tbl_vld_q[di] && (tbl_mac[di] == cur_dst);
	wire [PW-1:0]      hport   = tbl_port[di];
	wire [NP-1:0]      src_bit = {{(NP-1){1'b0}}, 1'b1} << sel_q;
	wire [NP-1:0]      hit_bit = {{(NP-1){1'b0}}, 1'b1} << hport;
	wire               learn   = (state_q == `ST_LOOK) && !cur_src[`GROUP_BIT];
	reg  [NP-1:0]      fwd_mask;
	always @* begin
		if (cur_dst[`GROUP_BIT])
			fwd_mask = ~src_bit;
		else if (hit && hport == sel_q)
			fwd_mask = {NP{1'b0}};
		else if (hit && hport < NP)
			fwd_mask = hit_bit;
		else
			fwd_mask = ~src_bit;
	end
	// egress may advance once every addressed port took the current byte
	wire go = ~(|tx_valid) | (&(tx_ready | ~tx_valid));
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= `ST_IDLE;
			mask_q   <= {NP{1'b0}};
			sel_q    <= {PW{1'b0}};
			rr_q     <= {PW{1'b0}};
			rel_q    <= {NP{1'b0}};
			rd_ptr_q <= {(FB_AW+1){1'b0}};
			tx_valid <= {NP{1'b0}};
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
		end else begin
			rel_q <= {NP{1'b0}};
			case (state_q)
				`ST_IDLE: begin
					if (pick_v && !(|rel_q)) begin
						sel_q   <= pick;
						rr_q    <= pick;
						state_q <= `ST_LOOK;
					end
				end
				`ST_LOOK: begin
					rd_ptr_q <= {(FB_AW+1){1'b0}};
					mask_q   <= fwd_mask;
					if (fwd_mask == {NP{1'b0}}) begin
						rel_q   <= src_bit;
						state_q <= `ST_IDLE;
					end else
						state_q <= `ST_SEND;
				end
				`ST_SEND: begin
					if (go) begin
						if (tx_last && |tx_valid) begin
							tx_valid <= {NP{1'b0}};
							tx_last  <= 1'b0;
							rel_q    <= src_bit;
							state_q  <= `ST_IDLE;
						end else begin
							tx_valid <= mask_q;
							tx_data  <= rd_bytes[sel_q*8 +: 8];
							tx_last  <= (rd_ptr_q == cur_len - 1'b1);
							rd_ptr_q <= rd_ptr_q + 1'b1;
						end
					end
				end
				default: state_q <= `ST_IDLE;
			endcase
		end
	end
	// table contents; no reset needed as the valid vector gates them
	always @(posedge sys_clk) begin
		if (learn) begin
			tbl_mac[si]  <= cur_src;
			tbl_port[si] <= sel_q;
		end
	end
	// valid and age bits: cleared in bulk only by reset, learning sets, sweep ages and evicts
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tbl_vld_q   <= {TD{1'b0}};
			tbl_age_q   <= {TD{1'b0}};
			age_cnt_q   <= 32'h0000_0000;
			sweep_q     <= 1'b0;
			sweep_idx_q <= {TD_AW{1'b0}};
		end else begin
			if (age_cnt_q >= AGE_CYCLES - 1) begin
				age_cnt_q <= 32'h0000_0000;
				sweep_q   <= 1'b1;
			end else
				age_cnt_q <= age_cnt_q + 32'h0000_0001;
			if (learn) begin
				tbl_vld_q[si] <= 1'b1;
				tbl_age_q[si] <= 1'b1;
			end else if (sweep_q && state_q != `ST_LOOK) begin
				// one entry per cycle, paused while a lookup writes
				if (tbl_age_q[sweep_idx_q])
					tbl_age_q[sweep_idx_q] <= 1'b0;
				else
					tbl_vld_q[sweep_idx_q] <= 1'b0;
				sweep_idx_q <= sweep_idx_q + 1'b1;
				if (&sweep_idx_q)
					sweep_q <= 1'b0;
			end
		end
	end
	// bad or overflowed frame counter
	reg [31:0] drop_inc;
	integer    k;
	always @* begin
		drop_inc = 32'h0000_0000;
		for (k = 0; k < NP; k = k + 1)
			drop_inc = drop_inc + {31'h0000_0000, bad_p[k]};
	end
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			drops_q <= 32'h0000_0000;
		else
			drops_q <= drops_q + drop_inc;
	end
	// register read: data stands the cycle after the strobe only
	reg [31:0] rmux;
	integer    m;
	always @* begin
		rmux = 32'h0000_0000;
		for (m = 0; m < NP; m = m + 1) begin
			if (reg_addr == `REG_CFG_BASE + m[7:0])
				rmux[`CFG_W-1:0] = cfg_v[m*`CFG_W +: `CFG_W];
			if (reg_addr == `REG_STS_BASE + m[7:0]) begin
				rmux[`STS_LINK] = link_up[m];
				rmux[`STS_SPD]  = port_100[m];
				rmux[`STS_FDX]  = port_full[m];
				rmux[`STS_MDIX] = mdix_sel[m];
				rmux[`STS_CONG] = pend[m];
			end
		end
		if (reg_addr == `REG_DROPS)
			rmux = drops_q;
		if (reg_addr == `REG_PDV)
			rmux[7:0] = `PATH_DELAY_BT;
	end
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rmux : 32'h0000_0000;
	end
endmodule // learning_switch_core

`default_nettype wire

// file: verification/learning_switch_core_sva.sv
// port level checks for the learning switch core
`timescale 1ns/1ps
`default_nettype none
`include "switch_map.vh"
module learning_switch_core_sva #(
	parameter NP = 4
) (
	input wire logic		sys_clk,
	input wire logic		rst_n,
	input wire logic [7:0]		reg_addr,
	input wire logic		reg_rd,
	input wire logic [31:0]		reg_rdata,
	input wire logic [NP-1:0]	rx_valid,
	input wire logic [NP-1:0]	tx_valid,
	input wire logic [7:0]		tx_data,
	input wire logic		tx_last,
	input wire logic [NP-1:0]	tx_ready,
	input wire logic [NP-1:0]	link_up,
	input wire logic [NP-1:0]	partner_an,
	input wire logic [NP*4-1:0]	partner_abil,
	input wire logic [NP-1:0]	partner_idle100,
	input wire logic [NP-1:0]	mdix_sel,
	input wire logic [NP-1:0]	port_100,
	input wire logic [NP-1:0]	port_full,
	input wire logic [NP-1:0]	force_col,
	input wire logic [NP-1:0]	pause_xoff,
	input wire logic [NP-1:0]	pause_xon
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// a stalled byte must stand still until every masked port takes it
	sequence s_stall;
		tx_valid != 0 && (tx_valid & ~tx_ready) != 0;
	endsequence
	sequence s_hold;
		$stable(tx_valid) && $stable(tx_data) && $stable(tx_last);
	endsequence
	sequence s_an_up;
		$rose(link_up[0]) && partner_an[0];
	endsequence
	AST_TX_HOLD: assert property (s_stall |=> s_hold)
		else $error("tx byte moved while stalled");
	AST_NEVER_INGRESS: assert property (tx_valid != 0 |-> $countones(tx_valid) < NP)
		else $error("frame sent to every port");
	AST_LAST_MASK: assert property (tx_last |-> tx_valid != 0)
		else $error("last byte without a port");
	AST_PDV: assert property (reg_rd && reg_addr == `REG_PDV |=> reg_rdata == 32'h0000_0032)
		else $error("path delay read wrong");
	AST_COL: assert property (force_col[2] |-> $past(rx_valid[2]) && !$past(port_full[2]))
		else $error("collision forced without cause");
	AST_XOFF: assert property (pause_xoff[0] |-> port_full[0] ##1 !pause_xoff[0])
		else $error("pause request wrong");
	AST_XON: assert property (pause_xon[0] |-> !pause_xoff[0] ##1 !pause_xon[0])
		else $error("resume request wrong");
	AST_MDIX: assert property ($changed(mdix_sel[0]) |-> !$past(link_up[0]))
		else $error("crossover moved with link up");
	AST_AN_BEST: assert property (s_an_up ##0 partner_abil[3] |-> ##[1:4] port_100[0] && port_full[0])
		else $error("best mode not chosen");
	AST_PARALLEL: assert property ($rose(link_up[0]) && !partner_an[0]
		|-> ##[1:4] port_100[0] == partner_idle100[0] && !port_full[0])
		else $error("parallel detect wrong");
endmodule // learning_switch_core_sva
bind learning_switch_core learning_switch_core_sva #(.NP(NP)) chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .link_up(link_up),
	.partner_an(partner_an), .partner_abil(partner_abil), .partner_idle100(partner_idle100),
	.mdix_sel(mdix_sel), .port_100(port_100), .port_full(port_full), .force_col(force_col),
	.pause_xoff(pause_xoff), .pause_xon(pause_xon));
`default_nettype wire

// file: verification/link_partner_model.sv
// behavioural link partners on every switched port
`timescale 1ns/1ps
`default_nettype none
module link_partner_model #(
	parameter NP = 4
) (
	input wire logic		sys_clk,
	output var logic [NP-1:0]	rx_valid,
	output var logic [NP*8-1:0]	rx_data,
	output var logic [NP-1:0]	rx_last,
	output var logic [NP-1:0]	rx_bad,
	input wire logic [NP-1:0]	tx_valid,
	input wire logic [7:0]		tx_data,
	input wire logic		tx_last,
	output var logic [NP-1:0]	tx_ready,
	output var logic [NP-1:0]	link_up,
	output var logic [NP-1:0]	partner_an,
	output var logic [NP*4-1:0]	partner_abil,
	output var logic [NP-1:0]	partner_idle100,
	input wire logic [NP-1:0]	force_col,
	input wire logic [NP-1:0]	pause_xoff,
	input wire logic [NP-1:0]	pause_xon
);
	logic [1:0]	rdy_mode [NP];
	logic [NP-1:0]	paused, col_seen, busy, mask_q;
	logic [7:0]	first_q;
	logic		phase;
	int		frames, xoffs, xons, cnt, len_q;
	initial begin
		{rx_valid, rx_last, rx_bad, tx_ready, link_up, partner_an, partner_idle100} = '0;
		{rx_data, partner_abil, paused, col_seen, busy, phase} = '0;
		{frames, xoffs, xons, cnt, len_q} = '0;
		foreach (rdy_mode[p]) rdy_mode[p] = 2'h0;
	end
	// idle data lines churn so a stale byte never looks valid
	always @(posedge sys_clk) begin
		phase <= ~phase;
		paused <= (paused | pause_xoff) & ~pause_xon;
		col_seen <= col_seen | force_col;
		xoffs <= xoffs + $countones(pause_xoff);
		xons <= xons + $countones(pause_xon);
		for (int p = 0; p < NP; p++) begin
			tx_ready[p] <= rdy_mode[p] == 0 || (rdy_mode[p] == 1 && phase);
			if (!busy[p])
				rx_data[p*8+:8] <= ~rx_data[p*8+:8];
		end
		if (tx_valid != 0 && (tx_valid & ~tx_ready) == 0) begin
			if (cnt == 0)
				first_q <= tx_data;
			cnt <= cnt + 1;
			if (tx_last) begin
				frames <= frames + 1;
				mask_q <= tx_valid;
				len_q <= cnt + 1;
				cnt <= 0;
			end
		end
	end
	// a paused sender holds off until resumed, bounded
	task automatic send(input int p, input logic [47:0] d, s, input int len, input logic bad);
		logic [95:0] hdr;
		hdr = {d, s};
		for (int w = 0; w < 2000 && paused[p]; w++) @(posedge sys_clk);
		busy[p] = 1'b1;
		for (int i = 0; i < len; i++) begin
			@(posedge sys_clk);
			rx_valid[p] <= 1'b1;
			rx_data[p*8+:8] <= (i < 12) ? hdr[95-8*i-:8] : i[7:0];
			rx_last[p] <= i == len - 1;
			rx_bad[p] <= bad && i == len - 1;
		end
		@(posedge sys_clk);
		{rx_valid[p], rx_last[p], rx_bad[p]} <= 3'h0;
		busy[p] = 1'b0;
	endtask
	// link bring-up or loss, with what the partner advertises
	task automatic link(input int p, input logic up, an, input logic [3:0] ab, input logic idle);
		@(posedge sys_clk);
		partner_an[p] <= an;
		partner_abil[p*4+:4] <= ab;
		partner_idle100[p] <= idle;
		link_up[p] <= up;
	endtask
endmodule // link_partner_model
`default_nettype wire

// file: verification/learning_switch_core_tb_top.sv
// self-checking bench for the learning switch core
`timescale 1ns/1ps
`default_nettype none
`include "switch_map.vh"
module learning_switch_core_tb_top;
	localparam NP = 4;
	localparam [47:0] A = 48'h0200_0000_000a, B = 48'h0200_0000_000b;
	localparam [47:0] C = 48'h0200_0000_000c, D = 48'h0200_0000_000d, MC = 48'h0100_5e00_0001;
	logic			sys_clk, rst_n, reg_wr, reg_rd, tx_last;
	logic [7:0]		reg_addr, tx_data;
	logic [31:0]		reg_wdata, reg_rdata, v, v2;
	logic [NP-1:0]		rx_valid, rx_last, rx_bad, tx_valid, tx_ready, link_up, partner_an;
	logic [NP-1:0]		partner_idle100, mdix_sel, port_100, port_full, force_col, pause_xoff, pause_xon;
	logic [NP*8-1:0]	rx_data;
	logic [NP*4-1:0]	partner_abil;
	int			n_fail, checks, n0, x0;
	learning_switch_core #(.NP(NP), .AGE_CYCLES(32'h0010_0000)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_bad(rx_bad), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .link_up(link_up), .partner_an(partner_an),
		.partner_abil(partner_abil), .partner_idle100(partner_idle100), .mdix_sel(mdix_sel),
		.port_100(port_100), .port_full(port_full), .force_col(force_col), .pause_xoff(pause_xoff),
		.pause_xon(pause_xon));
	link_partner_model #(.NP(NP)) pm (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rx_bad(rx_bad), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_ready(tx_ready), .link_up(link_up), .partner_an(partner_an), .partner_abil(partner_abil),
		.partner_idle100(partner_idle100), .force_col(force_col), .pause_xoff(pause_xoff),
		.pause_xon(pause_xon));
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// read data is taken in the one cycle it stands
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// one frame, then a bounded wait for its delivery or its absence
	task automatic fr(input int p, input logic [47:0] d, s, input logic bad, input logic [3:0] m);
		n0 = pm.frames;
		pm.send(p, d, s, 16, bad);
		for (int w = 0; w < 100 && pm.frames == n0; w++) @(posedge sys_clk);
		if (m == 0)
			chk(pm.frames, n0);
		else begin
			chk(pm.mask_q, m);
			chk(pm.len_q, 16);
			chk(pm.first_q, d[47:40]);
		end
	endtask
	task automatic t_regs();
		x0 = mdix_sel[3];
		for (int w = 0; w < 1000 && mdix_sel[3] == x0; w++) @(posedge sys_clk);
		chk(mdix_sel[3], !x0);
		for (int p = 0; p < NP; p++) begin
			rd(`REG_CFG_BASE + p, v);
			chk(v, 32'h0000_0001);
		end
		rd(`REG_PDV, v);
		chk(v, 32'h0000_0032);
		wr(8'h30, 32'hffff_ffff);
		rd(8'h30, v);
		chk(v, 32'h0000_0000);
		$display("test regs done");
	endtask
	task automatic t_neg();
		logic [5:0] tab [6] = '{6'h3e, 6'h2c, 6'h26, 6'h22, 6'h01, 6'h00};
		logic [1:0] ex [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0};
		for (int i = 0; i < 6; i++) begin
			pm.link(0, 0, tab[i][5], tab[i][4:1], tab[i][0]);
			repeat (3) @(posedge sys_clk);
			pm.link(0, 1, tab[i][5], tab[i][4:1], tab[i][0]);
			repeat (6) @(posedge sys_clk);
			chk({port_100[0], port_full[0]}, ex[i]);
		end
		pm.link(0, 0, 1, 4'hf, 0);
		wr(`REG_CFG_BASE + 1, 32'h0000_0006);
		pm.link(0, 1, 1, 4'hf, 0);
		pm.link(1, 1, 1, 4'hf, 0);
		pm.link(2, 1, 0, 4'h0, 1);
		pm.link(3, 1, 1, 4'hf, 0);
		repeat (6) @(posedge sys_clk);
		chk({port_100, port_full, mdix_sel[1]}, 9'h1f6);
		rd(`REG_STS_BASE + 1, v);
		chk(v, 32'h0000_0007);
		$display("test negotiation done");
	endtask
	task automatic t_fwd();
		fr(0, B, A, 0, 4'h0e);
		fr(1, A, B, 0, 4'h01);
		fr(0, A, D, 0, 4'h00);
		fr(3, MC, C, 0, 4'h07);
		rd(`REG_DROPS, v);
		fr(1, A, B, 1, 4'h00);
		rd(`REG_DROPS, v2);
		chk(v2, v + 1);
		fr(2, B, A, 0, 4'h02);
		fr(1, A, B, 0, 4'h04);
		pm.rdy_mode[3] = 2'h1;
		fr(0, C, D, 0, 4'h08);
		pm.rdy_mode[3] = 2'h0;
		$display("test forwarding done");
	endtask
	task automatic t_flow();
		pm.rdy_mode[1] = 2'h2;
		x0 = pm.xoffs;
		pm.send(0, B, D, 16, 0);
		repeat (5) @(posedge sys_clk);
		chk(pm.xoffs, x0 + 1);
		pm.send(2, B, C, 16, 0);
		pm.send(2, B, C, 16, 0);
		chk(pm.col_seen[2], 1'b1);
		x0 = pm.xons;
		n0 = pm.frames;
		pm.rdy_mode[1] = 2'h0;
		for (int w = 0; w < 300 && pm.frames < n0 + 2; w++) @(posedge sys_clk);
		chk(pm.frames, n0 + 2);
		chk(pm.xons, x0 + 1);
		$display("test flow control done");
	endtask
	task automatic final_report();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// whole run is a few thousand cycles, so this only trips on a hang
	initial begin
		#(25 * 20000);
		n_fail++;
		final_report();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, n_fail, checks} = '0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_neg();
		t_fwd();
		t_flow();
		final_report();
	end
endmodule // learning_switch_core_tb_top
`default_nettype wire
